// >>> sim/lvds_pixel_serializer_tx_test.sv
`default_nettype none
// ============================================================
// Bench.
module lvds_pixel_serializer_tx_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LOCK = 50;
    logic clk_sys = 0;
    logic sys_rst = 1;
    logic pclk = 0;
    logic sel = 0;
    logic pd_n = 1;
    logic [27:0] pix = '0;
    logic [3:0] lp;
    logic [3:0] ln;
    logic [3:0] loe;
    logic fcp;
    logic fcn;
    logic coe;
    logic locked;
    logic dropped;
    int errors = 0;
    int tests_run = 0;
    int drops = 0;
    always #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) drops <= drops + int'(dropped === 1'b1);
    lvds_pixel_serializer_tx #(.LOCK_CYCLES(LOCK)) DUT (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .pixel_clock_in(pclk),
        .strobe_edge_select(sel), .power_down_n(pd_n), .parallel_pixel_in(pix),
        .serial_lane_p(lp), .serial_lane_n(ln), .lane_oe_n(loe), .forwarded_clock_p(fcp),
        .forwarded_clock_n(fcn), .clock_oe_n(coe), .link_locked(locked),
        .pixel_dropped(dropped));
    lvds_rx_model rx (.clk_sys(clk_sys), .serial_lane_p(lp), .forwarded_clock_p(fcp),
        .clock_oe_n(coe));
    task check(input string what, input logic [27:0] seen, input logic [27:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task results;
        $display("Checks %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results
    task cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : cyc
    task send(input logic [27:0] a, input logic [27:0] b, input int q);
        pix = a;
        cyc(2);
        pclk = 1;
        cyc(q);
        pix = b;
        cyc(2);
        pclk = 0;
        cyc(q);
    endtask : send
    task wait_rx(input int n);
        int t;
        t = 0;
        while (rx.got.size() + drops < n && t < 400) begin
            cyc(1);
            t++;
        end
        if (t == 400) begin
            errors++;
            results();
        end
    endtask : wait_rx
    task wait_lock(output int n);
        n = 0;
        while (locked !== 1'b1 && n < 400) begin
            cyc(1);
            n++;
        end
        if (n == 400) begin
            errors++;
            results();
        end
    endtask : wait_lock
    task edge_test(input logic s);
        logic [27:0] a;
        sel = s;
        rx.got.delete();
        for (int i = 1; i < 7; i++) begin
            send(28'h9E3779B * 28'(i), ~(28'h9E3779B * 28'(i)), 2);
        end
        wait_rx(6);
        for (int i = 1; i < 7; i++) begin
            a = 28'h9E3779B * 28'(i);
            check("lane word", rx.got[i-1], s ? a : ~a);
        end
        $display("Edge test %0d done", s);
    endtask : edge_test
    task pd_test;
        int n;
        send(28'h0ABCDEF, 28'h0ABCDEF, 2);
        pd_n = 0;
        cyc(5);
        check("disabled", {loe, coe, locked}, 6'h3E);
        cyc(10);
        rx.got.delete();
        pd_n = 1;
        wait_lock(n);
        check("lock wait", 28'(n >= LOCK), 28'h1);
        send(28'h1234567, 28'h1234567, 2);
        wait_rx(1);
        check("after wake", rx.got[0], 28'h1234567);
        $display("Power-down test done");
    endtask : pd_test
    task fill_test;
        rx.got.delete();
        sel = 1;
        for (int i = 0; i < 200; i++) begin
            send(28'h0F0F0F0 + 28'(i), 28'h0F0F0F0 + 28'(i), 1);
        end
        wait_rx(200);
        check("drops", 28'(drops > 0), 28'h1);
        check("first kept", rx.got[0], 28'h0F0F0F0);
        $display("Fill test done");
    endtask : fill_test
    initial begin
        int n;
        cyc(16);
        sys_rst = 0;
        wait_lock(n);
        edge_test(1);
        edge_test(0);
        pd_test;
        fill_test;
        results();
    end
endmodule : lvds_pixel_serializer_tx_test
bind lvds_pixel_serializer_tx lvds_tx_properties props (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .power_down_n(power_down_n), .serial_lane_p(serial_lane_p),
    .serial_lane_n(serial_lane_n), .lane_oe_n(lane_oe_n),
    .forwarded_clock_p(forwarded_clock_p), .forwarded_clock_n(forwarded_clock_n),
    .clock_oe_n(clock_oe_n), .link_locked(link_locked));
`default_nettype wire

// >>> sim/lvds_rx_model.sv
`include "lvds_tx_defines.svh"
`default_nettype none
// ============================================================
// Receiver side of the link.
module lvds_rx_model (
    input wire logic clk_sys,
    input wire logic [`LANE_COUNT-1:0] serial_lane_p,
    input wire logic forwarded_clock_p,
    input wire logic clock_oe_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [`WORD_BITS-1:0] word;
    logic [`WORD_BITS-1:0] got[$];
    int slot = -1;
    always @(posedge clk_sys) begin
        if (clock_oe_n !== 1'b0) begin
            slot = -1;
        end else if (slot >= 0 || forwarded_clock_p === 1'b1) begin
            slot = (slot < 0) ? 0 : slot;
            for (int k = 0; k < 4; k++) begin
                word[k*7+slot] = serial_lane_p[k];
            end
            if (slot == 6) begin
                got.push_back(word);
                slot = -1;
            end else begin
                slot++;
            end
        end
    end
endmodule : lvds_rx_model
`default_nettype wire

// >>> sim/lvds_tx_properties.sv
`include "lvds_tx_defines.svh"
`default_nettype none
// ============================================================
// Output checks.
module lvds_tx_properties (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic power_down_n,
    input wire logic [`LANE_COUNT-1:0] serial_lane_p,
    input wire logic [`LANE_COUNT-1:0] serial_lane_n,
    input wire logic [`LANE_COUNT-1:0] lane_oe_n,
    input wire logic forwarded_clock_p,
    input wire logic forwarded_clock_n,
    input wire logic clock_oe_n,
    input wire logic link_locked
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    lane_pair_a: assert property (serial_lane_n == ~serial_lane_p)
        else $error("lane pair");
    clock_pair_a: assert property (forwarded_clock_n == ~forwarded_clock_p)
        else $error("clock pair");
    oe_match_a: assert property (lane_oe_n == {4{clock_oe_n}})
        else $error("enables differ");
    pd_off_a: assert property ($fell(power_down_n) |-> ##[1:5] lane_oe_n == 4'hF)
        else $error("late disable");
    pd_hold_a: assert property (!power_down_n [*3] |=>
        clock_oe_n && serial_lane_p == 4'h0 && !link_locked)
        else $error("not disabled");
    fclk_wide_a: assert property ($rose(forwarded_clock_p) |=> forwarded_clock_p)
        else $error("clock slot");
    lock_wait_a: assert property ($fell(clock_oe_n) |-> !link_locked [*8])
        else $error("early lock");
    locked_en_a: assert property (link_locked |-> !clock_oe_n)
        else $error("locked off");
endmodule : lvds_tx_properties
`default_nettype wire

// >>> src/lvds_pixel_serializer_tx.sv
// Operation
// - Strobe select high captures the parallel word on pixel clock rising edges.
// - Strobe select low captures the parallel word on pixel clock falling edges.
// - An open strobe select reads low, giving falling-edge capture; the code has no pull-down, so an open select gives an X capture.
// - Power-down low puts every data and clock output in high impedance.
// - Four differential data lanes plus one differential forwarded clock lane.
// - Each lane sends seven bits, 0 to 6, in evenly spaced slots.
// - Outputs reach the disabled state within 100 ns of power-down.
// - Serial output is only valid after the 10 ms lock interval.
`include "lvds_tx_defines.svh"
`default_nettype none
module lvds_pixel_serializer_tx
    import lvds_tx_pkg::*;
#(
    parameter int LOCK_CYCLES = `LOCK_CYCLES_DEF,
    parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic pixel_clock_in,
    input wire logic strobe_edge_select,
    input wire logic power_down_n,
    input wire logic [`WORD_BITS-1:0] parallel_pixel_in,
    output logic [`LANE_COUNT-1:0] serial_lane_p,
    output logic [`LANE_COUNT-1:0] serial_lane_n,
    output logic [`LANE_COUNT-1:0] lane_oe_n,
    output logic forwarded_clock_p,
    output logic forwarded_clock_n,
    output logic clock_oe_n,
    output logic link_locked,
    output logic pixel_dropped
);
    // ======================================================================
    // Input synchronisers.
    logic pclk_s1_q;
    logic pclk_s2_q;
    logic pclk_prev_q;
    logic sel_s1_q;
    logic sel_s2_q;
    logic pd_s1_q;
    logic pd_s2_q;
    logic [`WORD_BITS-1:0] data_s1_q;
    logic [`WORD_BITS-1:0] data_s2_q;
    logic [`WORD_BITS-1:0] data_s3_q;

    always_ff @(posedge clk_sys) begin
        pclk_s1_q <= pixel_clock_in;
        pclk_s2_q <= pclk_s1_q;
        pclk_prev_q <= pclk_s2_q;
        sel_s1_q <= strobe_edge_select;
        sel_s2_q <= sel_s1_q;
        pd_s1_q <= power_down_n;
        pd_s2_q <= pd_s1_q;
        data_s1_q <= parallel_pixel_in;
        data_s2_q <= data_s1_q;
        data_s3_q <= data_s2_q;
    end

    // ======================================================================
    // Edge selection and capture.
    logic pclk_rise;
    logic pclk_fall;
    logic capture;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [`WORD_BITS-1:0] fifo_out_data;
    tx_state_t state_q;
    tx_state_t state_d;

    always_comb begin
        pclk_rise = pclk_s2_q && !pclk_prev_q;
        pclk_fall = !pclk_s2_q && pclk_prev_q;
        // A high select picks the rising edge.
        // A low select picks the falling edge; an undriven select gives an X capture.
        capture = (state_q == ST_RUN) && (sel_s2_q ? pclk_rise : pclk_fall);
    end

    // The word sampled one cycle before the edge was seen, so hold time is not relied on.
    pixel_fifo #(
        .WIDTH(`WORD_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .flush(state_q != ST_RUN),
        .in_valid(capture),
        .in_ready(fifo_in_ready),
        .in_data(data_s3_q),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // ======================================================================
    // Power and lock sequencing.
    logic [$clog2(LOCK_CYCLES+1)-1:0] lock_cnt_q;
    logic [$clog2(LOCK_CYCLES+1)-1:0] lock_cnt_d;

    always_comb begin
        state_d = state_q;
        lock_cnt_d = lock_cnt_q;
        unique case (state_q)
            ST_OFF: begin
                lock_cnt_d = '0;
                if (pd_s2_q) begin
                    state_d = ST_LOCK;
                end
            end
            ST_LOCK: begin
                lock_cnt_d = lock_cnt_q + 1'b1;
                // Hold the serial stream off until the lock interval elapses.
                if (lock_cnt_q == ($clog2(LOCK_CYCLES+1))'(LOCK_CYCLES - 1)) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
            end
            default: begin
                state_d = ST_OFF;
            end
        endcase
        if (!pd_s2_q) begin
            state_d = ST_OFF;
        end
        if (sys_rst) begin
            state_d = ST_OFF;
            lock_cnt_d = '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        state_q <= state_d;
        lock_cnt_q <= lock_cnt_d;
    end

    // ======================================================================
    // Serializer.
    logic [`WORD_BITS-1:0] word_q;
    logic [`WORD_BITS-1:0] word_d;
    slot_t slot_q;
    slot_t slot_d;
    logic busy_q;
    logic busy_d;
    logic [`LANE_COUNT-1:0] lane_bit;
    logic [`LANE_COUNT-1:0] lane_q;
    logic [`LANE_COUNT-1:0] lane_d;
    logic [`LANE_COUNT-1:0] oe_n_q;
    logic [`LANE_COUNT-1:0] oe_n_d;
    logic [`LANE_COUNT-1:0] lane_n_q;
    logic fclk_q;
    logic fclk_d;
    logic fclk_n_q;
    logic fclk_oe_n_q;
    logic fclk_oe_n_d;
    logic locked_q;
    logic dropped_q;
    logic [`LANE_BITS-1:0] clk_pattern;

    assign clk_pattern = `CLK_PATTERN;

    genvar k;
    generate
        for (k = 0; k < `LANE_COUNT; k++) begin : g_lane
            // Lane k carries word bits k*7 to k*7+6, bit 0 first.
            assign lane_bit[k] = word_q[k * `LANE_BITS + int'(slot_q)];
        end
    endgenerate

    always_comb begin
        fifo_out_ready = (state_q == ST_RUN) && (!busy_q || slot_q == `LAST_SLOT);
        word_d = word_q;
        slot_d = slot_q;
        busy_d = busy_q;
        if (busy_q) begin
            // One bit per slot, seven equal slots per word.
            slot_d = slot_q + 3'h1;
        end
        if (busy_q && slot_q == `LAST_SLOT) begin
            busy_d = 1'b0;
            slot_d = 3'h0;
        end
        if (fifo_out_valid && fifo_out_ready) begin
            word_d = fifo_out_data;
            busy_d = 1'b1;
            slot_d = 3'h0;
        end
        lane_d = '0;
        fclk_d = 1'b0;
        if (busy_q) begin
            // Four data lanes plus a forwarded clock lane.
            lane_d = lane_bit;
            fclk_d = clk_pattern[`LAST_SLOT - slot_q];
        end
        // Power-down disables every output three cycles after the pin falls.
        oe_n_d = {`LANE_COUNT{!pd_s2_q}};
        fclk_oe_n_d = !pd_s2_q;
        if (!pd_s2_q) begin
            lane_d = '0;
        end
        if (state_q != ST_RUN || sys_rst) begin
            busy_d = 1'b0;
            slot_d = 3'h0;
            word_d = '0;
        end
        if (sys_rst) begin
            lane_d = '0;
            fclk_d = 1'b0;
            oe_n_d = '1;
            fclk_oe_n_d = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        word_q <= word_d;
        slot_q <= slot_d;
        busy_q <= busy_d;
        lane_q <= lane_d;
        lane_n_q <= ~lane_d;
        oe_n_q <= oe_n_d;
        fclk_q <= fclk_d;
        fclk_n_q <= ~fclk_d;
        fclk_oe_n_q <= fclk_oe_n_d;
        locked_q <= !sys_rst && pd_s2_q && state_q == ST_RUN;
        dropped_q <= !sys_rst && capture && !fifo_in_ready;
    end

    always_comb begin
        serial_lane_p = lane_q;
        serial_lane_n = lane_n_q;
        lane_oe_n = oe_n_q;
        forwarded_clock_p = fclk_q;
        forwarded_clock_n = fclk_n_q;
        clock_oe_n = fclk_oe_n_q;
        link_locked = locked_q;
        pixel_dropped = dropped_q;
    end
endmodule : lvds_pixel_serializer_tx
`default_nettype wire

// >>> src/lvds_tx_defines.svh
`ifndef LVDS_TX_DEFINES_SVH
`define LVDS_TX_DEFINES_SVH

// ==========================================================================
// Word layout.
`define WORD_BITS 28
`define LANE_COUNT 4
`define LANE_BITS 7
`define LAST_SLOT 3'h6
`define FIFO_DEPTH 16

// ==========================================================================
// Forwarded clock level per slot, slot 0 in the most significant bit.
`define CLK_PATTERN 7'h63

// ==========================================================================
// Timing.
`define CLK_MHZ 50
`define CLK_PERIOD_NS 20
`define LOCK_TIME_MS 10
`define LOCK_CYCLES_DEF (`LOCK_TIME_MS * 1000 * `CLK_MHZ)
`define PD_DELAY_NS 100
`define PD_DELAY_CYCLES (`PD_DELAY_NS / `CLK_PERIOD_NS)

`endif

// >>> src/lvds_tx_pkg.sv
`default_nettype none
package lvds_tx_pkg;
    typedef enum logic [1:0] {ST_OFF, ST_LOCK, ST_RUN} tx_state_t;
    typedef logic [2:0] slot_t;
endpackage : lvds_tx_pkg
`default_nettype wire

// >>> src/pixel_fifo.sv
`default_nettype none
module pixel_fifo #(
    parameter int WIDTH = 28,
    parameter int DEPTH = 16
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] wr_d;
    logic [AW:0] rd_q;
    logic [AW:0] rd_d;
    logic push;
    logic pop;

    // ======================================================================
    // Pointer arithmetic with one wrap bit for honest full and empty.
    always_comb begin
        in_ready = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
        out_valid = (wr_q != rd_q);
        out_data = mem_q[rd_q[AW-1:0]];
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wr_d = wr_q + (AW+1)'(push);
        rd_d = rd_q + (AW+1)'(pop);
        if (sys_rst || flush) begin
            wr_d = '0;
            rd_d = '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        wr_q <= wr_d;
        rd_q <= rd_d;
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end
endmodule : pixel_fifo
`default_nettype wire
